// *** core/ccr_pkg.sv ***
// ccr_pkg: constants, request types and layouts for the core register block
package ccr_pkg;

  // ----------------------------------------------------------------
  // special-register offsets (same in both banks)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STACK_PTR = 8'h81;
  localparam logic [7:0] ADDR_PTR0_LOW = 8'h82;
  localparam logic [7:0] ADDR_PTR0_HIGH = 8'h83;
  localparam logic [7:0] ADDR_PTR1_LOW = 8'h84;
  localparam logic [7:0] ADDR_PTR1_HIGH = 8'h85;
  localparam logic [7:0] ADDR_MODE = 8'h86;
  localparam logic [7:0] ADDR_STATUS = 8'hd0;
  localparam logic [7:0] ADDR_MAIN_OPER = 8'he0;
  localparam logic [7:0] ADDR_SECOND_OPER = 8'hf0;
  localparam logic [7:0] ADDR_EXT_OPER = 8'hf1;
  localparam logic [7:0] ADDR_EXTERNAL_RAM_PAGE = 8'hf7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_PTR_BIT = 0;
  localparam int MODE_MUL_BIT = 2;
  localparam int MODE_DIV_BIT = 3;
  localparam int MODE_BANK_BIT = 6;
  localparam logic [7:0] MODE_WR_MASK = 8'h4d;
  localparam int PSW_CY_BIT = 7;
  localparam int PSW_AC_BIT = 6;
  localparam int PSW_F0_BIT = 5;
  localparam int PSW_RS_LSB = 3;
  localparam int PSW_OV_BIT = 2;
  localparam int PSW_F1_BIT = 1;
  localparam int PSW_P_BIT = 0;
  localparam int EXTERNAL_RAM_PAGE_W = 6;

  // ----------------------------------------------------------------
  // reset values and memory layout
  // ----------------------------------------------------------------
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [EXTERNAL_RAM_PAGE_W-1:0] EXTERNAL_RAM_PAGE_RST = 6'h00;
  localparam logic [15:0] DISP_BASE = 16'h01e0;
  localparam int DISP_LEN = 19;
  localparam int XRAM_LEN = 256;

  // ----------------------------------------------------------------
  // requests from the instruction sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CCR_OP_IDLE, CCR_OP_RD_DIR, CCR_OP_RD_IND, CCR_OP_WR_DIR,
    CCR_OP_WR_IND, CCR_OP_RD_REG, CCR_OP_WR_REG, CCR_OP_PUSH,
    CCR_OP_POP, CCR_OP_XRD, CCR_OP_XWR, CCR_OP_MUL, CCR_OP_DIV,
    CCR_OP_ADD, CCR_OP_SUB, CCR_OP_INC_PTR
  } ccr_op_t;

  typedef struct packed {
    ccr_op_t op;
    logic [7:0] addr;
    logic [2:0] regIdx;
    logic [7:0] wdata;
    logic viaPtr;
    logic withCarry;
  } ccr_req_t;

  typedef struct packed {
    logic wr;
    logic bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccr_ext_sfr_t;

endpackage

// *** core/ccr_core_regs.sv ***
// ccr_core_regs: core registers, stack, arithmetic flags and memory decode
`timescale 1ns/100ps

// Function
// - stack pointer is 8 bits; push and call increment first, then write
// - pop and returns read the current location first, then decrement
// - any reset loads the stack pointer with 07h
// - the stack reaches all 256 internal RAM locations
// - primary pointer: two byte registers, also usable as one 16-bit value
// - register group select maps R0-R7 onto one of four 8-byte groups
// - parity flag always follows accumulator odd parity; writes ignored
// - add and subtract set carry, half carry, overflow; clear them otherwise
// - user flags at bits 5 and 1 change only by software writes
// - narrow multiply: low byte to accumulator, high byte to second reg
// - wide multiply: extension and accumulator times second register
// - narrow divide: quotient to accumulator, remainder to second reg
// - wide divide: 16-bit dividend, quotient high byte to extension
// - after reset multiply and divide are narrow until mode bits are set
// - extension and second register are plain scratch otherwise
// - pointer choice bit routes pointer operations to primary or secondary
// - bank choice bit steers special-register accesses to bank 0 or 1
// - lower internal RAM is reached directly and indirectly
// - above 7fh indirect reaches upper RAM, direct reaches special regs
// - 256 bytes external RAM by register-indirect or pointer moves
// - 19 display RAM bytes at 1e0h-1f2h by pointer moves
module ccr_core_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // sequencer request
  input ccr_pkg::ccr_req_t coreReq,
  // answers and views
  output logic [7:0] rdData,
  output logic sfrBankSel,
  output logic [15:0] activePointer,
  output ccr_pkg::ccr_ext_sfr_t extSfr
);
  import ccr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] mainOperand_r, mainOperand_nxt;
  logic [7:0] secondOperand_r, secondOperand_nxt;
  logic [7:0] extOperand_r, extOperand_nxt;
  logic [7:0] stackTopPtr_r, stackTopPtr_nxt;
  logic [7:0] statusFlags_r, statusFlags_nxt;
  logic [15:0] primaryPtr_r, primaryPtr_nxt;
  logic [15:0] secondaryPtr_r, secondaryPtr_nxt;
  logic [7:0] modeSelect_r, modeSelect_nxt;
  logic [EXTERNAL_RAM_PAGE_W-1:0] extRamPage_r, extRamPage_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  ccr_ext_sfr_t extSfr_r, extSfr_nxt;
  logic [7:0] intRam_r [256];
  logic [7:0] intRam_nxt [256];
  logic [7:0] extRam_r [XRAM_LEN];
  logic [7:0] extRam_nxt [XRAM_LEN];
  logic [7:0] dispRam_r [DISP_LEN];
  logic [7:0] dispRam_nxt [DISP_LEN];

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  logic parityBit;
  logic [7:0] statusView;
  logic [15:0] selPtr;
  logic [7:0] regAddr;
  logic [7:0] sfrRdData;
  logic [15:0] extAddr;
  logic extRamHit;
  logic dispHit;
  logic [4:0] dispIdx;
  logic [15:0] prodNarrow;
  logic [23:0] prodWide;
  logic [7:0] divisor;
  logic [15:0] dividend;
  logic [15:0] quotient;
  logic [7:0] remainder;
  logic [8:0] sumFull;
  logic [4:0] sumNibble;

  assign parityBit = ^mainOperand_r;
  assign statusView = {statusFlags_r[7:1], parityBit};
  assign selPtr = modeSelect_r[MODE_PTR_BIT] ? secondaryPtr_r
                                             : primaryPtr_r;
  assign regAddr = {3'b000, statusFlags_r[PSW_RS_LSB +: 2], coreReq.regIdx};
  // page only extends register-indirect moves
  assign extAddr = coreReq.viaPtr ? selPtr
                                  : {2'b00, extRamPage_r, coreReq.addr};
  assign extRamHit = (extAddr[15:8] == 8'h00);
  // display RAM is a pointer-only window
  assign dispHit = coreReq.viaPtr && (extAddr >= DISP_BASE) &&
                   (extAddr < DISP_BASE + 16'(DISP_LEN));
  assign dispIdx = 5'(extAddr - DISP_BASE);
  assign prodNarrow = 16'(mainOperand_r) * 16'(secondOperand_r);
  assign prodWide = 24'({extOperand_r, mainOperand_r}) *
                    24'(secondOperand_r);
  // a zero divisor is replaced only to keep simulation free of unknowns
  assign divisor = (secondOperand_r == 8'h00) ? 8'h01 : secondOperand_r;
  assign dividend = modeSelect_r[MODE_DIV_BIT]
                    ? {extOperand_r, mainOperand_r}
                    : {8'h00, mainOperand_r};
  assign quotient = dividend / 16'(divisor);
  assign remainder = 8'(dividend % 16'(divisor));
  assign sumFull = coreReq.op == CCR_OP_SUB
    ? {1'b0, mainOperand_r} - {1'b0, coreReq.wdata} -
      9'(coreReq.withCarry & statusFlags_r[PSW_CY_BIT])
    : {1'b0, mainOperand_r} + {1'b0, coreReq.wdata} +
      9'(coreReq.withCarry & statusFlags_r[PSW_CY_BIT]);
  assign sumNibble = coreReq.op == CCR_OP_SUB
    ? {1'b0, mainOperand_r[3:0]} - {1'b0, coreReq.wdata[3:0]} -
      5'(coreReq.withCarry & statusFlags_r[PSW_CY_BIT])
    : {1'b0, mainOperand_r[3:0]} + {1'b0, coreReq.wdata[3:0]} +
      5'(coreReq.withCarry & statusFlags_r[PSW_CY_BIT]);

  // ----------------------------------------------------------------
  // special-register read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (coreReq.addr)
      ADDR_STACK_PTR: sfrRdData = stackTopPtr_r;
      ADDR_PTR0_LOW: sfrRdData = primaryPtr_r[7:0];
      ADDR_PTR0_HIGH: sfrRdData = primaryPtr_r[15:8];
      ADDR_PTR1_LOW: sfrRdData = secondaryPtr_r[7:0];
      ADDR_PTR1_HIGH: sfrRdData = secondaryPtr_r[15:8];
      ADDR_MODE: sfrRdData = modeSelect_r;
      ADDR_STATUS: sfrRdData = statusView;
      ADDR_MAIN_OPER: sfrRdData = mainOperand_r;
      ADDR_SECOND_OPER: sfrRdData = secondOperand_r;
      ADDR_EXT_OPER: sfrRdData = extOperand_r;
      ADDR_EXTERNAL_RAM_PAGE: sfrRdData = {2'b00, extRamPage_r};
      // peripheral registers live outside; their reads are not muxed here
      default: sfrRdData = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next-state
  // ----------------------------------------------------------------
  always_comb begin
    mainOperand_nxt = mainOperand_r;
    secondOperand_nxt = secondOperand_r;
    extOperand_nxt = extOperand_r;
    stackTopPtr_nxt = stackTopPtr_r;
    statusFlags_nxt = statusFlags_r;
    primaryPtr_nxt = primaryPtr_r;
    secondaryPtr_nxt = secondaryPtr_r;
    modeSelect_nxt = modeSelect_r;
    extRamPage_nxt = extRamPage_r;
    rdData_nxt = rdData_r;
    extSfr_nxt = '0;
    intRam_nxt = intRam_r;
    extRam_nxt = extRam_r;
    dispRam_nxt = dispRam_r;
    unique case (coreReq.op)
      CCR_OP_IDLE: ;
      CCR_OP_RD_DIR: begin
        rdData_nxt = coreReq.addr[7] ? sfrRdData : intRam_r[coreReq.addr];
      end
      CCR_OP_RD_IND: rdData_nxt = intRam_r[coreReq.addr];
      CCR_OP_WR_IND: intRam_nxt[coreReq.addr] = coreReq.wdata;
      CCR_OP_WR_DIR: begin
        if (!coreReq.addr[7]) begin
          intRam_nxt[coreReq.addr] = coreReq.wdata;
        end else begin
          case (coreReq.addr)
            ADDR_STACK_PTR: stackTopPtr_nxt = coreReq.wdata;
            ADDR_PTR0_LOW: primaryPtr_nxt[7:0] = coreReq.wdata;
            ADDR_PTR0_HIGH: primaryPtr_nxt[15:8] = coreReq.wdata;
            ADDR_PTR1_LOW: secondaryPtr_nxt[7:0] = coreReq.wdata;
            ADDR_PTR1_HIGH: secondaryPtr_nxt[15:8] = coreReq.wdata;
            ADDR_MODE: modeSelect_nxt = coreReq.wdata & MODE_WR_MASK;
            // parity is computed, never stored
            ADDR_STATUS: statusFlags_nxt = {coreReq.wdata[7:1], 1'b0};
            ADDR_MAIN_OPER: mainOperand_nxt = coreReq.wdata;
            ADDR_SECOND_OPER: secondOperand_nxt = coreReq.wdata;
            ADDR_EXT_OPER: extOperand_nxt = coreReq.wdata;
            ADDR_EXTERNAL_RAM_PAGE: extRamPage_nxt = coreReq.wdata[EXTERNAL_RAM_PAGE_W-1:0];
            default: begin
              extSfr_nxt.wr = 1'b1;
              extSfr_nxt.bank = modeSelect_r[MODE_BANK_BIT];
              extSfr_nxt.addr = coreReq.addr;
              extSfr_nxt.wdata = coreReq.wdata;
            end
          endcase
        end
      end
      CCR_OP_RD_REG: rdData_nxt = intRam_r[regAddr];
      CCR_OP_WR_REG: intRam_nxt[regAddr] = coreReq.wdata;
      CCR_OP_PUSH: begin
        stackTopPtr_nxt = stackTopPtr_r + 8'h01;
        intRam_nxt[stackTopPtr_nxt] = coreReq.wdata;
      end
      CCR_OP_POP: begin
        rdData_nxt = intRam_r[stackTopPtr_r];
        stackTopPtr_nxt = stackTopPtr_r - 8'h01;
      end
      CCR_OP_XRD: begin
        // outside both windows reads as zero
        if (dispHit) rdData_nxt = dispRam_r[dispIdx];
        else if (extRamHit) rdData_nxt = extRam_r[extAddr[7:0]];
        else rdData_nxt = 8'h00;
      end
      CCR_OP_XWR: begin
        if (dispHit) dispRam_nxt[dispIdx] = coreReq.wdata;
        else if (extRamHit) begin
          extRam_nxt[extAddr[7:0]] = coreReq.wdata;
        end
      end
      CCR_OP_MUL: begin
        statusFlags_nxt[PSW_CY_BIT] = 1'b0;
        if (modeSelect_r[MODE_MUL_BIT]) begin
          mainOperand_nxt = prodWide[7:0];
          secondOperand_nxt = prodWide[15:8];
          extOperand_nxt = prodWide[23:16];
          statusFlags_nxt[PSW_OV_BIT] = |prodWide[23:16];
        end else begin
          mainOperand_nxt = prodNarrow[7:0];
          secondOperand_nxt = prodNarrow[15:8];
          statusFlags_nxt[PSW_OV_BIT] = |prodNarrow[15:8];
        end
      end
      CCR_OP_DIV: begin
        statusFlags_nxt[PSW_CY_BIT] = 1'b0;
        statusFlags_nxt[PSW_OV_BIT] = (secondOperand_r == 8'h00);
        if (secondOperand_r != 8'h00) begin
          mainOperand_nxt = quotient[7:0];
          secondOperand_nxt = remainder;
          if (modeSelect_r[MODE_DIV_BIT]) extOperand_nxt = quotient[15:8];
        end
      end
      CCR_OP_ADD, CCR_OP_SUB: begin
        mainOperand_nxt = sumFull[7:0];
        statusFlags_nxt[PSW_CY_BIT] = sumFull[8];
        statusFlags_nxt[PSW_AC_BIT] = sumNibble[4];
        statusFlags_nxt[PSW_OV_BIT] = (coreReq.op == CCR_OP_SUB)
          ? (mainOperand_r[7] != coreReq.wdata[7]) &&
            (sumFull[7] != mainOperand_r[7])
          : (mainOperand_r[7] == coreReq.wdata[7]) &&
            (sumFull[7] != mainOperand_r[7]);
      end
      CCR_OP_INC_PTR: begin
        if (modeSelect_r[MODE_PTR_BIT]) secondaryPtr_nxt = selPtr + 16'h0001;
        else primaryPtr_nxt = selPtr + 16'h0001;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mainOperand_r <= 8'h00;
      secondOperand_r <= 8'h00;
      extOperand_r <= 8'h00;
      stackTopPtr_r <= SP_RST;
      statusFlags_r <= PSW_RST;
      primaryPtr_r <= 16'h0000;
      secondaryPtr_r <= 16'h0000;
      modeSelect_r <= MODE_RST;
      extRamPage_r <= EXTERNAL_RAM_PAGE_RST;
      rdData_r <= 8'h00;
      extSfr_r <= '0;
      for (int i = 0; i < 256; i++) intRam_r[i] <= 8'h00;
      for (int i = 0; i < XRAM_LEN; i++) extRam_r[i] <= 8'h00;
      for (int i = 0; i < DISP_LEN; i++) dispRam_r[i] <= 8'h00;
    end else begin
      mainOperand_r <= mainOperand_nxt;
      secondOperand_r <= secondOperand_nxt;
      extOperand_r <= extOperand_nxt;
      stackTopPtr_r <= stackTopPtr_nxt;
      statusFlags_r <= statusFlags_nxt;
      primaryPtr_r <= primaryPtr_nxt;
      secondaryPtr_r <= secondaryPtr_nxt;
      modeSelect_r <= modeSelect_nxt;
      extRamPage_r <= extRamPage_nxt;
      rdData_r <= rdData_nxt;
      extSfr_r <= extSfr_nxt;
      intRam_r <= intRam_nxt;
      extRam_r <= extRam_nxt;
      dispRam_r <= dispRam_nxt;
    end
  end

  assign rdData = rdData_r;
  assign sfrBankSel = modeSelect_r[MODE_BANK_BIT];
  assign activePointer = selPtr;
  assign extSfr = extSfr_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_sp_reset_value: assert property (
    $fell(sys_rst) |-> stackTopPtr_r == SP_RST && modeSelect_r == MODE_RST)
    else $error("stack pointer or mode not at reset value");
  a_push_inc_first: assert property (
    coreReq.op == CCR_OP_PUSH |=> stackTopPtr_r == $past(stackTopPtr_r) +
    8'h01 && intRam_r[stackTopPtr_r] == $past(coreReq.wdata))
    else $error("push did not pre-increment and store");
  a_pop_read_first: assert property (
    coreReq.op == CCR_OP_POP |=> rdData == $past(intRam_r[stackTopPtr_r]) &&
    stackTopPtr_r == $past(stackTopPtr_r) - 8'h01)
    else $error("pop did not read then decrement");
  a_parity_tracks: assert property (
    coreReq.op == CCR_OP_RD_DIR && coreReq.addr == ADDR_STATUS |=>
    rdData[PSW_P_BIT] == ^$past(mainOperand_r))
    else $error("parity flag wrong");
  a_group_select_map: assert property (
    coreReq.op == CCR_OP_WR_REG |=> intRam_r[{3'b000,
    $past(statusFlags_r[4:3]), $past(coreReq.regIdx)}] == $past(coreReq.wdata))
    else $error("working register landed in wrong group");
  a_user_flags_hold: assert property (
    !(coreReq.op == CCR_OP_WR_DIR && coreReq.addr == ADDR_STATUS) |=>
    $stable(statusFlags_r[PSW_F0_BIT]) && $stable(statusFlags_r[PSW_F1_BIT]))
    else $error("user flag changed by hardware");
  a_mul_narrow: assert property (
    coreReq.op == CCR_OP_MUL && !modeSelect_r[MODE_MUL_BIT] |=>
    {secondOperand_r, mainOperand_r} ==
    16'($past(mainOperand_r)) * 16'($past(secondOperand_r)))
    else $error("narrow product wrong");
  a_mul_wide: assert property (
    coreReq.op == CCR_OP_MUL && modeSelect_r[MODE_MUL_BIT] |=>
    {extOperand_r, secondOperand_r, mainOperand_r} ==
    24'({$past(extOperand_r), $past(mainOperand_r)}) *
    24'($past(secondOperand_r)))
    else $error("wide product wrong");
  a_div_narrow: assert property (
    coreReq.op == CCR_OP_DIV && !modeSelect_r[MODE_DIV_BIT] &&
    secondOperand_r != 8'h00 |=>
    mainOperand_r == $past(mainOperand_r) / $past(secondOperand_r) &&
    secondOperand_r == $past(mainOperand_r) % $past(secondOperand_r))
    else $error("narrow divide wrong");
  a_div_zero_flags: assert property (
    coreReq.op == CCR_OP_DIV && secondOperand_r == 8'h00 |=>
    statusFlags_r[PSW_OV_BIT] && !statusFlags_r[PSW_CY_BIT])
    else $error("divide by zero flags wrong");
  a_add_carry_out: assert property (
    coreReq.op == CCR_OP_ADD && !coreReq.withCarry |=>
    statusFlags_r[PSW_CY_BIT] ==
    (9'($past(mainOperand_r)) + 9'($past(coreReq.wdata)) > 9'h0ff))
    else $error("carry flag wrong after add");
  a_ptr_choice_route: assert property (
    coreReq.op == CCR_OP_INC_PTR && modeSelect_r[MODE_PTR_BIT] |=>
    $stable(primaryPtr_r) && secondaryPtr_r == $past(secondaryPtr_r) + 16'h1)
    else $error("pointer choice not honoured");
  a_upper_split: assert property (
    coreReq.op == CCR_OP_WR_IND && coreReq.addr[7] |=>
    $stable(mainOperand_r) && $stable(statusFlags_r) && !extSfr.wr)
    else $error("indirect write reached special registers");

endmodule

// *** tb/ccr_core_regs_tb.sv ***
// ccr_core_regs_tb: self-checking bench for the core register block
`timescale 1ns/100ps
module ccr_core_regs_tb;
  import ccr_pkg::*;
  // ----------------------------------------------------------------
  // clock, reset and design
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  ccr_req_t coreReq = '0;
  logic [7:0] rdData;
  logic sfrBankSel;
  logic [15:0] activePointer;
  ccr_ext_sfr_t extSfr;
  int nErrors = 0;
  int checksDone = 0;
  int cycleCnt = 0;
  logic [31:0] rnd = 32'h509a5fdd;
  logic [7:0] a, b, e, x, acc;
  logic [23:0] r;
  logic cy;

  always #25 sys_clk = ~sys_clk;

  ccr_core_regs ccr_core_regs_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .coreReq(coreReq), .rdData(rdData), .sfrBankSel(sfrBankSel),
    .activePointer(activePointer), .extSfr(extSfr));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function logic [7:0] rb();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd[7:0];
  endfunction

  // returns {carry, half carry, overflow, result}
  function automatic logic [10:0] arith(input logic sub,
      input logic [7:0] p, q, input logic c);
    logic [8:0] s;
    logic h;
    logic v;
    if (sub) begin
      s = {1'b0, p} - {1'b0, q} - 9'(c);
      h = {1'b0, p[3:0]} < ({1'b0, q[3:0]} + 5'(c));
      v = (p[7] != q[7]) && (s[7] != p[7]);
    end else begin
      s = {1'b0, p} + {1'b0, q} + 9'(c);
      h = ({1'b0, p[3:0]} + {1'b0, q[3:0]} + 5'(c)) > 5'h0f;
      v = (p[7] == q[7]) && (s[7] != p[7]);
    end
    return {s[8], h, v, s[7:0]};
  endfunction

  // one request per call, with an idle cycle after it
  task automatic run(input ccr_op_t op, input logic [7:0] ad, wd,
      input logic [2:0] ix = 3'h0, input logic vp = 1'b0,
      input logic wc = 1'b0);
    @(negedge sys_clk);
    coreReq <= '{op: op, addr: ad, regIdx: ix, wdata: wd, viaPtr: vp,
      withCarry: wc};
    @(negedge sys_clk);
    coreReq.op <= CCR_OP_IDLE;
  endtask

  task automatic chk(input logic [23:0] seen, exp);
    checksDone++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdChk(input ccr_op_t op, input logic [7:0] ad, exp,
      input logic vp = 1'b0);
    run(op, ad, 8'h00, 3'h0, vp);
    chk({16'h0, rdData}, {16'h0, exp});
  endtask

  task automatic loadOps(input logic [7:0] pa, pb, pe);
    run(CCR_OP_WR_DIR, ADDR_MAIN_OPER, pa);
    run(CCR_OP_WR_DIR, ADDR_SECOND_OPER, pb);
    run(CCR_OP_WR_DIR, ADDR_EXT_OPER, pe);
  endtask

  task automatic testDone();
    $display("checks %0d, errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // the whole sequence needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycleCnt++;
    if (cycleCnt == 4000) begin
      nErrors++;
      testDone();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge sys_clk);
    sys_rst <= 1'b0;
    rdChk(CCR_OP_RD_DIR, ADDR_STACK_PTR, SP_RST);
    rdChk(CCR_OP_RD_DIR, ADDR_MODE, MODE_RST);
    rdChk(CCR_OP_RD_DIR, ADDR_STATUS, PSW_RST);
    rdChk(CCR_OP_RD_DIR, ADDR_EXTERNAL_RAM_PAGE, 8'h00);
    chk({23'h0, sfrBankSel}, 24'h0);
    a = rb();
    b = rb();
    run(CCR_OP_PUSH, 8'h00, a);
    rdChk(CCR_OP_RD_DIR, ADDR_STACK_PTR, 8'h08);
    rdChk(CCR_OP_RD_IND, 8'h08, a);
    run(CCR_OP_PUSH, 8'h00, b);
    rdChk(CCR_OP_POP, 8'h00, b);
    rdChk(CCR_OP_RD_DIR, ADDR_STACK_PTR, 8'h08);
    run(CCR_OP_WR_DIR, ADDR_STACK_PTR, 8'hfe);
    run(CCR_OP_PUSH, 8'h00, b);
    rdChk(CCR_OP_RD_IND, 8'hff, b);
    for (int g = 0; g < 4; g++) begin
      a = rb();
      run(CCR_OP_WR_DIR, ADDR_STATUS, 8'(g << 3));
      run(CCR_OP_WR_REG, 8'h00, a, 3'h5);
      rdChk(CCR_OP_RD_IND, 8'(g * 8 + 5), a);
    end
    a = rb();
    b = rb();
    run(CCR_OP_WR_IND, 8'h90, a);
    chk({23'h0, extSfr.wr}, 24'h0);
    run(CCR_OP_WR_DIR, 8'h30, b);
    rdChk(CCR_OP_RD_IND, 8'h90, a);
    rdChk(CCR_OP_RD_DIR, 8'h90, 8'h00);
    rdChk(CCR_OP_RD_IND, 8'h30, b);
    for (int k = 0; k < 2; k++) begin
      a = rb();
      run(CCR_OP_WR_DIR, ADDR_MODE, k ? 8'hff : 8'h00);
      chk({23'h0, sfrBankSel}, 24'(k));
      run(CCR_OP_WR_DIR, 8'h90, a);
      chk({6'h0, extSfr}, {6'h0, 1'b1, k[0], 8'h90, a});
      @(negedge sys_clk);
      chk({23'h0, extSfr.wr}, 24'h0);
    end
    rdChk(CCR_OP_RD_DIR, ADDR_MODE, MODE_WR_MASK);
    a = rb();
    b = rb() & 8'h7f;
    e = rb();
    run(CCR_OP_WR_DIR, ADDR_PTR0_LOW, a);
    run(CCR_OP_WR_DIR, ADDR_PTR0_HIGH, b);
    run(CCR_OP_WR_DIR, ADDR_PTR1_LOW, 8'hff);
    run(CCR_OP_WR_DIR, ADDR_PTR1_HIGH, e);
    chk({8'h0, activePointer}, {8'h0, e, 8'hff});
    run(CCR_OP_INC_PTR, 8'h00, 8'h00);
    rdChk(CCR_OP_RD_DIR, ADDR_PTR1_HIGH, e + 8'h01);
    rdChk(CCR_OP_RD_DIR, ADDR_PTR1_LOW, 8'h00);
    run(CCR_OP_WR_DIR, ADDR_MODE, 8'h00);
    chk({8'h0, activePointer}, {8'h0, b, a});
    run(CCR_OP_INC_PTR, 8'h00, 8'h00);
    chk({8'h0, activePointer}, {8'h0, b, a} + 24'h1);
    x = rb();
    a = rb();
    run(CCR_OP_WR_DIR, ADDR_PTR0_HIGH, 8'h00);
    run(CCR_OP_WR_DIR, ADDR_PTR0_LOW, x);
    run(CCR_OP_XWR, 8'h00, a, 3'h0, 1'b1);
    rdChk(CCR_OP_XRD, x, a);
    run(CCR_OP_WR_DIR, ADDR_EXTERNAL_RAM_PAGE, 8'hff);
    rdChk(CCR_OP_RD_DIR, ADDR_EXTERNAL_RAM_PAGE, 8'h3f);
    rdChk(CCR_OP_XRD, x, 8'h00);
    run(CCR_OP_WR_DIR, ADDR_EXTERNAL_RAM_PAGE, 8'h00);
    // top display byte, then the first address past it
    for (int k = 0; k < 2; k++) begin
      a = rb();
      run(CCR_OP_WR_DIR, ADDR_PTR0_HIGH, 8'h01);
      run(CCR_OP_WR_DIR, ADDR_PTR0_LOW, k ? 8'hf3 : 8'hf2);
      run(CCR_OP_XWR, 8'h00, a, 3'h0, 1'b1);
      rdChk(CCR_OP_XRD, 8'h00, k ? 8'h00 : a, 1'b1);
    end
    // second reset in mid-run: arithmetic must come back narrow
    run(CCR_OP_WR_DIR, ADDR_MODE, 8'h0c);
    @(negedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst <= 1'b0;
    rdChk(CCR_OP_RD_DIR, ADDR_STACK_PTR, SP_RST);
    rdChk(CCR_OP_RD_DIR, ADDR_MODE, MODE_RST);
    for (int w = 0; w < 2; w++) begin
      if (w) run(CCR_OP_WR_DIR, ADDR_MODE, 8'h0c);
      a = rb();
      b = rb() | 8'h01;
      e = rb();
      loadOps(a, b, e);
      run(CCR_OP_MUL, 8'h00, 8'h00);
      r = w ? 24'({e, a}) * 24'(b) : 24'(a) * 24'(b);
      rdChk(CCR_OP_RD_DIR, ADDR_MAIN_OPER, r[7:0]);
      rdChk(CCR_OP_RD_DIR, ADDR_SECOND_OPER, r[15:8]);
      rdChk(CCR_OP_RD_DIR, ADDR_EXT_OPER, w ? r[23:16] : e);
      run(CCR_OP_RD_DIR, ADDR_STATUS, 8'h00);
      chk({22'h0, rdData[7], rdData[2]},
        {23'h0, w ? |r[23:16] : |r[15:8]});
      loadOps(a, b, e);
      run(CCR_OP_DIV, 8'h00, 8'h00);
      r = w ? 24'({e, a} / b) : 24'(a / b);
      x = w ? 8'({e, a} % b) : 8'(a % b);
      rdChk(CCR_OP_RD_DIR, ADDR_MAIN_OPER, r[7:0]);
      rdChk(CCR_OP_RD_DIR, ADDR_SECOND_OPER, x);
      rdChk(CCR_OP_RD_DIR, ADDR_EXT_OPER, w ? r[15:8] : e);
      loadOps(a, 8'h00, e);
      run(CCR_OP_DIV, 8'h00, 8'h00);
      run(CCR_OP_RD_DIR, ADDR_STATUS, 8'h00);
      chk({22'h0, rdData[7], rdData[2]}, 24'h1);
      rdChk(CCR_OP_RD_DIR, ADDR_MAIN_OPER, a);
    end
    acc = rb();
    run(CCR_OP_WR_DIR, ADDR_MAIN_OPER, acc);
    run(CCR_OP_WR_DIR, ADDR_STATUS, {7'b0010001, ~^acc});
    rdChk(CCR_OP_RD_DIR, ADDR_STATUS, {7'b0010001, ^acc});
    cy = 1'b0;
    for (int i = 0; i < 40; i++) begin
      a = rb();
      x = rb();
      r[10:0] = arith(x[0], acc, a, x[1] & cy);
      run(x[0] ? CCR_OP_SUB : CCR_OP_ADD, 8'h00, a, 3'h0, 1'b0, x[1]);
      acc = r[7:0];
      cy = r[10];
      run(CCR_OP_RD_DIR, ADDR_STATUS, 8'h00);
      chk({16'h0, rdData},
        {16'h0, r[10:9], 3'b100, r[8], 1'b1, ^acc});
    end
    rdChk(CCR_OP_RD_DIR, ADDR_MAIN_OPER, acc);
    testDone();
  end
endmodule
